// ===== verilog/ssrct_defines.svh
`ifndef SSRCT_DEFINES_SVH
`define SSRCT_DEFINES_SVH

// ****************************************
// APB register byte offsets
// ****************************************
`define SSRCT_ADDR_CTRL      8'h00
`define SSRCT_ADDR_WDATA_LO  8'h04
`define SSRCT_ADDR_WDATA_HI  8'h08
`define SSRCT_ADDR_CMD       8'h0C
`define SSRCT_ADDR_RDATA_LO  8'h10
`define SSRCT_ADDR_RDATA_HI  8'h14
`define SSRCT_ADDR_STATUS    8'h18
`define SSRCT_ADDR_IRQ       8'h1C
`define SSRCT_ADDR_FPSTATE   8'h20

// ****************************************
// State-register numbers
// ****************************************
`define SSRCT_ASR_MULDIV     5'h00
`define SSRCT_ASR_CCODES     5'h02
`define SSRCT_ASR_ASID       5'h03
`define SSRCT_ASR_CORE_CNT   5'h04
`define SSRCT_ASR_PC         5'h05
`define SSRCT_ASR_FP_REGISTER_STATUS       5'h06
`define SSRCT_ASR_PERF_CTL   5'h10
`define SSRCT_ASR_PERF_VAL   5'h11
`define SSRCT_ASR_GFX        5'h13
`define SSRCT_ASR_SINT_SET   5'h14
`define SSRCT_ASR_SINT_CLR   5'h15
`define SSRCT_ASR_SINT       5'h16
`define SSRCT_ASR_CORE_CMP   5'h17
`define SSRCT_ASR_SYS_CNT    5'h18
`define SSRCT_ASR_SYS_CMP    5'h19

// ****************************************
// Field positions and fixed values
// ****************************************
`define SSRCT_CTRL_STRAND_LSB 0
`define SSRCT_CTRL_MODE_LSB   4
`define SSRCT_CTRL_PEF_BIT    8
`define SSRCT_CTRL_IE_BIT     9
`define SSRCT_CTRL_PIL_LSB    12
`define SSRCT_CTRL_CNTEN_BIT  16
`define SSRCT_CMD_WRITE_BIT   8
`define SSRCT_SINT_CORE_BIT   0
`define SSRCT_SINT_SOFT_BIT   14
`define SSRCT_SINT_SYS_BIT    16
`define SSRCT_CMP_DIS_BIT     63
`define SSRCT_NPT_BIT         63
`define SSRCT_PCR_GUARD_BIT   0
`define SSRCT_FP_ENABLE_STATUS_BIT    2
`define SSRCT_FSR_VER_MASK    32'h000E2000
// Address field only: it sits in bits 47:2 of the program counter
`define SSRCT_PC_VEC_NORMAL   46'h3FFFFC000008
`define SSRCT_PC_VEC_ALT      48'h000000000020
`define SSRCT_SYS_LOW_ONES    7'h7F
`define SSRCT_CMP_RESET       64'h8000000000000000
`define SSRCT_PIL_SYS         4'hE
`define SSRCT_PIL_OTHER       4'h4

`endif

// ===== verilog/ssrct_pkg.sv
`default_nettype none

package ssrct_pkg;

  typedef enum logic [1:0] {
    MODE_USER  = 2'b00,
    MODE_PRIV  = 2'b01,
    MODE_HPRIV = 2'b11
  } ssrct_mode_t;

  typedef enum logic [2:0] {
    TRAP_NONE        = 3'h0,
    TRAP_BAD_OPCODE  = 3'h1,
    TRAP_PRIV_OP     = 3'h2,
    TRAP_PRIV_ACCESS = 3'h3,
    TRAP_FLOAT_OFF   = 3'h4
  } ssrct_trap_t;

  typedef struct packed {
    logic [4:0] asr;
    logic       write;
  } ssrct_cmd_t;

  typedef struct packed {
    ssrct_trap_t trap;
    logic [63:0] data;
  } ssrct_result_t;

endpackage : ssrct_pkg

`default_nettype wire

// ===== verilog/ssrct_regs.sv
`include "ssrct_defines.svh"
`default_nettype none

// Notes on behaviour
// - Reserved numbers raise bad-opcode trap
// - Core counter: npt read guard, non-hyper write traps
// - Program counter write raises bad-opcode
// - User access to privileged registers traps
// - Perf counter guarded by control guard bit
// - Soft set/clear write-only, user writes trap
// - System counter: npt guard, non-hyper write traps
// - Shared counter, per-strand read-block bit
// - Counter increments while enable set
// - Warm reset sets read-block, counter untouched
// - PC sign-extended, low two bits zero
// - PC power-on value picked by vector select
// - FP state version and queue fields zero
// - Graphics status traps when Float_off_trap
// - Three level-14 pending bits stay independent
// - System match sets flag, threshold fourteen
// - Other level-14 sources use threshold four
// - Core compare on bits 62:7, disable bit
// - System compare on bits 62:7, disable bit
// - Both counter names share one register
// - System counter reads low bits as ones
// - Each compare scanned within 128 cycles
module ssrct_regs
  import ssrct_pkg::*;
#(
  parameter int STRANDS = 8
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                warmResetPin,
  input  wire logic                resetVectorSelectPin,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [STRANDS-1:0]  irqLevel14
);

  localparam int SW = $clog2(STRANDS);
  localparam int SCAN_W = SW + 1;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic warmMeta;
  logic warmSync;
  logic vecMeta;
  logic vecSync;

  always_ff @(posedge clock) begin
    warmMeta <= warmResetPin;
    warmSync <= warmMeta;
    vecMeta  <= resetVectorSelectPin;
    vecSync  <= vecMeta;
  end

  // ****************************************
  // APB decode
  // ****************************************
  wire logic apbSetup = psel & ~penable;
  wire logic apbWrite = psel & penable & pready & pwrite;
  wire logic hitCtrl  = paddr == `SSRCT_ADDR_CTRL;
  wire logic hitWdLo  = paddr == `SSRCT_ADDR_WDATA_LO;
  wire logic hitWdHi  = paddr == `SSRCT_ADDR_WDATA_HI;
  wire logic hitCmd   = paddr == `SSRCT_ADDR_CMD;
  wire logic hitRdLo  = paddr == `SSRCT_ADDR_RDATA_LO;
  wire logic hitRdHi  = paddr == `SSRCT_ADDR_RDATA_HI;
  wire logic hitStat  = paddr == `SSRCT_ADDR_STATUS;
  wire logic hitIrq   = paddr == `SSRCT_ADDR_IRQ;
  wire logic hitFsr   = paddr == `SSRCT_ADDR_FPSTATE;
  wire logic hitAny   = hitCtrl | hitWdLo | hitWdHi | hitCmd | hitRdLo | hitRdHi | hitStat | hitIrq | hitFsr;

  // ****************************************
  // Software-visible context and staging
  // ****************************************
  logic [31:0]   ctrl;
  logic [31:0]   wdLo;
  logic [31:0]   wdHi;
  ssrct_cmd_t    lastCmd;
  ssrct_result_t result;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= 32'h00000000;
      wdLo <= 32'h00000000;
      wdHi <= 32'h00000000;
    end else begin
      if (apbWrite && hitCtrl) begin
        ctrl <= pwdata;
      end
      if (apbWrite && hitWdLo) begin
        wdLo <= pwdata;
      end
      if (apbWrite && hitWdHi) begin
        wdHi <= pwdata;
      end
    end
  end

  wire logic [SW-1:0]  strand   = ctrl[`SSRCT_CTRL_STRAND_LSB +: SW];
  wire ssrct_mode_t    mode     = ssrct_mode_t'(ctrl[`SSRCT_CTRL_MODE_LSB +: 2]);
  wire logic           pefBit   = ctrl[`SSRCT_CTRL_PEF_BIT];
  wire logic           ieBit    = ctrl[`SSRCT_CTRL_IE_BIT];
  wire logic [3:0]     current_irq_priority      = ctrl[`SSRCT_CTRL_PIL_LSB +: 4];
  wire logic           countEn  = ctrl[`SSRCT_CTRL_CNTEN_BIT];
  wire logic [63:0]    wdata    = {wdHi, wdLo};
  wire logic           isUser   = mode == MODE_USER;
  wire logic           isHyper  = mode == MODE_HPRIV;

  wire logic           cmdGo    = apbWrite & hitCmd;
  wire logic [4:0]     cmdAsr   = pwdata[4:0];
  wire logic           cmdWr    = pwdata[`SSRCT_CMD_WRITE_BIT];

  // ****************************************
  // Per-strand storage and shared counter
  // ****************************************
  logic [63:0]        genReg   [STRANDS][6];
  logic [7:0]         fp_register_status     [STRANDS];
  logic [16:0]        sint     [STRANDS];
  logic [63:0]        coreCmp  [STRANDS];
  logic [63:0]        sysCmp   [STRANDS];
  logic [47:0]        pcReg    [STRANDS];
  logic [31:0]        fp_state_register      [STRANDS];
  logic [STRANDS-1:0] npt;
  logic [62:0]        counter;

  localparam int G_MULDIV = 0;
  localparam int G_CCODES = 1;
  localparam int G_ASID   = 2;
  localparam int G_PCTL   = 3;
  localparam int G_PVAL   = 4;
  localparam int G_GFX    = 5;

  // Sign-extended view, low two bits cleared
  wire logic [47:0] pcCur  = pcReg[strand];
  wire logic [63:0] pcView = {{16{pcCur[47]}}, pcCur[47:2], 2'b00};
  wire logic [63:0] cntView = {npt[strand], counter};
  // Low bits forced so a compare above the read value still matches
  wire logic [63:0] sysView = {npt[strand], counter[62:7], `SSRCT_SYS_LOW_ONES};

  // ****************************************
  // Access check and read selection
  // ****************************************
  ssrct_trap_t trap;
  logic [63:0] rdSel;

  always_comb begin
    trap  = TRAP_NONE;
    rdSel = 64'h0000000000000000;
    case (cmdAsr)
      `SSRCT_ASR_MULDIV: rdSel = genReg[strand][G_MULDIV];
      `SSRCT_ASR_CCODES: rdSel = genReg[strand][G_CCODES];
      `SSRCT_ASR_ASID: rdSel = genReg[strand][G_ASID];
      `SSRCT_ASR_FP_REGISTER_STATUS: rdSel = {56'h0, fp_register_status[strand]};
      `SSRCT_ASR_CORE_CNT: begin
        rdSel = cntView;
        if (cmdWr && isUser) begin
          trap = TRAP_PRIV_OP;
        end else if (cmdWr && !isHyper) begin
          trap = TRAP_BAD_OPCODE;
        end else if (!cmdWr && isUser && npt[strand]) begin
          trap = TRAP_PRIV_ACCESS;
        end
      end
      `SSRCT_ASR_SYS_CNT: begin
        rdSel = sysView;
        if (cmdWr && !isHyper) begin
          trap = TRAP_BAD_OPCODE;
        end else if (!cmdWr && isUser && npt[strand]) begin
          trap = TRAP_PRIV_ACCESS;
        end
      end
      `SSRCT_ASR_PC: begin
        rdSel = pcView;
        if (cmdWr) begin
          trap = TRAP_BAD_OPCODE;
        end
      end
      `SSRCT_ASR_PERF_CTL: begin
        rdSel = genReg[strand][G_PCTL];
        if (isUser) begin
          trap = TRAP_PRIV_OP;
        end
      end
      `SSRCT_ASR_PERF_VAL: begin
        rdSel = genReg[strand][G_PVAL];
        if (isUser && genReg[strand][G_PCTL][`SSRCT_PCR_GUARD_BIT]) begin
          trap = TRAP_PRIV_ACCESS;
        end
      end
      `SSRCT_ASR_GFX: begin
        rdSel = genReg[strand][G_GFX];
        if (!pefBit || !fp_register_status[strand][`SSRCT_FP_ENABLE_STATUS_BIT]) begin
          trap = TRAP_FLOAT_OFF;
        end
      end
      `SSRCT_ASR_SINT_SET, `SSRCT_ASR_SINT_CLR: begin
        if (!cmdWr) begin
          trap = TRAP_BAD_OPCODE;
        end else if (isUser) begin
          trap = TRAP_PRIV_OP;
        end
      end
      `SSRCT_ASR_SINT, `SSRCT_ASR_CORE_CMP, `SSRCT_ASR_SYS_CMP: begin
        rdSel = (cmdAsr == `SSRCT_ASR_SINT) ? {47'h0, sint[strand]} :
                (cmdAsr == `SSRCT_ASR_CORE_CMP) ? coreCmp[strand] : sysCmp[strand];
        if (isUser) begin
          trap = TRAP_PRIV_OP;
        end
      end
      default: trap = TRAP_BAD_OPCODE;
    endcase
  end

  wire logic doWrite = cmdGo & cmdWr & (trap == TRAP_NONE);
  wire logic wrCnt   = doWrite & ((cmdAsr == `SSRCT_ASR_CORE_CNT) | (cmdAsr == `SSRCT_ASR_SYS_CNT));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lastCmd <= '0;
      result  <= '{trap: TRAP_NONE, data: 64'h0000000000000000};
    end else if (cmdGo) begin
      lastCmd <= '{asr: cmdAsr, write: cmdWr};
      result  <= '{trap: trap, data: (cmdWr || trap != TRAP_NONE) ? 64'h0000000000000000 : rdSel};
    end
  end

  // ****************************************
  // Shared counter and read-block bits
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      counter <= 63'h0;
    end else if (wrCnt) begin
      counter <= wdata[62:0];
    end else if (countEn) begin
      counter <= counter + 63'h1;
    end
  end

  // Warm reset never touches the counter above
  always_ff @(posedge clock) begin
    if (sys_rst || warmSync) begin
      npt <= '1;
    end else if (wrCnt) begin
      npt[strand] <= wdata[`SSRCT_NPT_BIT];
    end
  end

  // ****************************************
  // Compare scan
  // ****************************************
  // One compare per cycle keeps one comparator; 2*STRANDS cycles per pass
  logic [SCAN_W-1:0] scanIdx;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scanIdx <= '0;
    end else begin
      scanIdx <= scanIdx + SCAN_W'(1);
    end
  end

  wire logic [SW-1:0] scanStrand = scanIdx[SCAN_W-1:1];
  wire logic          scanSys    = scanIdx[0];
  wire logic [63:0]   scanCmp    = scanSys ? sysCmp[scanStrand] : coreCmp[scanStrand];
  wire logic          scanMatch  = scanCmp[62:7] == counter[62:7];
  wire logic          scanPost   = scanMatch & ~scanCmp[`SSRCT_CMP_DIS_BIT];

  // ****************************************
  // Strand state update
  // ****************************************
  wire logic isStrWr = doWrite;

  always_ff @(posedge clock) begin
    for (int i = 0; i < STRANDS; i++) begin
      if (sys_rst) begin
        for (int g = 0; g < 6; g++) begin
          genReg[i][g] <= 64'h0000000000000000;
        end
        fp_register_status[i]    <= 8'h00;
        coreCmp[i] <= `SSRCT_CMP_RESET;
        sysCmp[i]  <= `SSRCT_CMP_RESET;
        pcReg[i]   <= vecSync ? `SSRCT_PC_VEC_ALT : {`SSRCT_PC_VEC_NORMAL, 2'b00};
      end else if (isStrWr && strand == SW'(i)) begin
        case (cmdAsr)
          `SSRCT_ASR_MULDIV: genReg[i][G_MULDIV] <= wdata;
          `SSRCT_ASR_CCODES: genReg[i][G_CCODES] <= wdata;
          `SSRCT_ASR_ASID: genReg[i][G_ASID] <= wdata;
          `SSRCT_ASR_PERF_CTL: genReg[i][G_PCTL] <= wdata;
          `SSRCT_ASR_PERF_VAL: genReg[i][G_PVAL] <= wdata;
          `SSRCT_ASR_GFX: genReg[i][G_GFX] <= wdata;
          `SSRCT_ASR_FP_REGISTER_STATUS: fp_register_status[i] <= wdata[7:0];
          `SSRCT_ASR_CORE_CMP: coreCmp[i] <= wdata;
          `SSRCT_ASR_SYS_CMP: sysCmp[i] <= wdata;
          default: fp_register_status[i] <= fp_register_status[i];
        endcase
      end
    end
  end

  // Floating-point state: version and queue fields never store a one
  always_ff @(posedge clock) begin
    for (int i = 0; i < STRANDS; i++) begin
      if (sys_rst) begin
        fp_state_register[i] <= 32'h00000000;
      end else if (apbWrite && hitFsr && strand == SW'(i)) begin
        fp_state_register[i] <= pwdata & ~`SSRCT_FSR_VER_MASK;
      end
    end
  end

  // ****************************************
  // Soft-interrupt pending bits
  // ****************************************
  // Hardware posting is applied last, so a match wins over a clear
  always_ff @(posedge clock) begin
    for (int i = 0; i < STRANDS; i++) begin
      if (sys_rst) begin
        sint[i] <= 17'h00000;
      end else begin
        if (isStrWr && strand == SW'(i) && cmdAsr == `SSRCT_ASR_SINT) begin
          sint[i] <= wdata[16:0];
        end else if (isStrWr && strand == SW'(i) && cmdAsr == `SSRCT_ASR_SINT_SET) begin
          sint[i] <= sint[i] | wdata[16:0];
        end else if (isStrWr && strand == SW'(i) && cmdAsr == `SSRCT_ASR_SINT_CLR) begin
          sint[i] <= sint[i] & ~wdata[16:0];
        end
        if (scanPost && scanStrand == SW'(i)) begin
          // Each source sets only its own bit
          if (scanSys) begin
            sint[i][`SSRCT_SINT_SYS_BIT] <= 1'b1;
          end else begin
            sint[i][`SSRCT_SINT_CORE_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Level-14 request per strand
  // ****************************************
  always_ff @(posedge clock) begin
    for (int i = 0; i < STRANDS; i++) begin
      if (sys_rst) begin
        irqLevel14[i] <= 1'b0;
      end else begin
        irqLevel14[i] <= ieBit &
          ((sint[i][`SSRCT_SINT_SYS_BIT] & (current_irq_priority < `SSRCT_PIL_SYS)) |
           ((sint[i][`SSRCT_SINT_CORE_BIT] | sint[i][`SSRCT_SINT_SOFT_BIT]) & (current_irq_priority < `SSRCT_PIL_OTHER)));
      end
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  wire logic [31:0] rdMux =
    hitCtrl ? ctrl :
    hitWdLo ? wdLo :
    hitWdHi ? wdHi :
    hitCmd  ? {23'h0, lastCmd.write, 3'h0, lastCmd.asr} :
    hitRdLo ? result.data[31:0] :
    hitRdHi ? result.data[63:32] :
    hitStat ? {29'h0, result.trap} :
    hitIrq  ? {{(32 - STRANDS){1'b0}}, irqLevel14} :
    hitFsr  ? fp_state_register[strand] : 32'h00000000;

  // Answer prepared in setup, so access always completes in one cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~hitAny;
      prdata  <= (apbSetup && !pwrite) ? rdMux : 32'h00000000;
    end
  end

endmodule : ssrct_regs

`default_nettype wire

// ===== testbench/ssrct_properties.sv
`default_nettype none

module ssrct_properties #(
  parameter int STRANDS = 8
) (
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [STRANDS-1:0] irqLevel14
);
  // ****************************************
  // Bus handshake, decode and fixed fields
  // ****************************************
  wire logic mapped;
  wire logic setupNow;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h20);
  assign setupNow = psel && !penable;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence read_done_s;
    pready && !pwrite;
  endsequence

  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("no ready in first access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable && $past(setupNow))
    else $error("ready outside an access phase");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");
  unmapped_error_a: assert property (setup_s ##0 !mapped |=> pslverr)
    else $error("unmapped address not flagged");
  mapped_no_error_a: assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped address flagged");
  error_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  trap_code_range_a: assert property (read_done_s ##0 paddr == 8'h18 |-> prdata <= 32'h4)
    else $error("status holds an unknown trap code");
  fp_fixed_zero_a: assert property (read_done_s ##0 paddr == 8'h20 |-> (prdata & 32'h000E2000) == 32'h0)
    else $error("fixed floating-point fields not zero");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !pready && irqLevel14 == '0)
    else $error("outputs active right after reset");
endmodule : ssrct_properties

`default_nettype wire

// ===== testbench/test_strand_state_regs_cycle_timer.sv
`include "ssrct_defines.svh"
`default_nettype none

module test_strand_state_regs_cycle_timer
  import ssrct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [16:0] USR = 17'h00100;
  localparam logic [16:0] PRV = 17'h00110;
  localparam logic [16:0] HYP = 17'h00130;
  localparam logic [16:0] CNT = 17'h10000;
  localparam logic [16:0] IE3 = 17'h03330;
  localparam logic [16:0] IE4 = 17'h04330;

  logic        clock = 1'h0;
  logic        sys_rst = 1'h1;
  logic        warmResetPin = 1'h0;
  logic        resetVectorSelectPin = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  irqLevel14;
  logic [31:0] rdw;
  logic        errw;
  logic [63:0] rd;
  logic [63:0] prev;
  logic [2:0]  trap;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  ssrct_regs #(.STRANDS(8)) u_dut (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .warmResetPin        (warmResetPin),
    .resetVectorSelectPin(resetVectorSelectPin),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .irqLevel14          (irqLevel14)
  );

  initial begin
    forever #2.5 clock = ~clock;
  end

  // Run is about 2700 cycles; a hang stops at the 12000-cycle budget
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      stop_test();
    end
  end

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Leaves the bus held so transfers chain back to back
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rdw = prdata;
    errw = pslverr;
  endtask : apb

  task automatic idle();
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : idle

  task automatic do_reset(input int n);
    sys_rst <= 1'h1;
    repeat (n) @(posedge clock);
    sys_rst <= 1'h0;
    @(posedge clock);
  endtask : do_reset

  // Fixed 15-cycle spacing between command edges
  task automatic sr(input logic [16:0] c, input logic [4:0] n, input logic w, input logic [63:0] d);
    apb(1'h1, `SSRCT_ADDR_CTRL, {15'h0, c});
    apb(1'h1, `SSRCT_ADDR_WDATA_LO, d[31:0]);
    apb(1'h1, `SSRCT_ADDR_WDATA_HI, d[63:32]);
    apb(1'h1, `SSRCT_ADDR_CMD, {23'h0, w, 3'h0, n});
    apb(1'h0, `SSRCT_ADDR_STATUS, 32'h0);
    trap = rdw[2:0];
    apb(1'h0, `SSRCT_ADDR_RDATA_LO, 32'h0);
    rd[31:0] = rdw;
    apb(1'h0, `SSRCT_ADDR_RDATA_HI, 32'h0);
    rd[63:32] = rdw;
    idle();
  endtask : sr

  task automatic tr(input logic [16:0] c, input logic [4:0] n, input logic w, input logic [63:0] d,
                    input ssrct_trap_t e);
    sr(c, n, w, d);
    check(trap, e, "trap");
    if (w || e != TRAP_NONE) begin
      check(rd, 64'h0, "rdata");
    end
  endtask : tr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bus();
    apb(1'h1, 8'h40, 32'hFFFFFFFF);
    check(errw, 1'h1, "err wr");
    apb(1'h0, 8'h02, 32'h0);
    idle();
    check({errw, rdw}, 33'h100000000, "err rd");
    apb(1'h1, `SSRCT_ADDR_FPSTATE, 32'hFFFFFFFF);
    apb(1'h0, `SSRCT_ADDR_FPSTATE, 32'h0);
    idle();
    check({errw, rdw}, 33'h0FFF1DFFF, "fsr");
  endtask : t_bus

  task automatic t_pc();
    sr(HYP, 5'h05, 1'h0, 64'h0);
    check(rd, 64'hFFFFFFFFF0000020, "pc");
    tr(HYP, 5'h05, 1'h1, 64'h0, TRAP_BAD_OPCODE);
    resetVectorSelectPin <= 1'h1;
    do_reset(8);
    sr(HYP, 5'h05, 1'h0, 64'h0);
    check(rd, 64'h20, "pc alt");
  endtask : t_pc

  task automatic t_reserved();
    for (int n = 0; n < 32; n++) begin
      for (int w = 0; w < 2; w++) begin
        if (n == 1 || (n >= 7 && n <= 14) || n == 18 || n >= 26) begin
          tr(HYP, n[4:0], w[0], 64'h0, TRAP_BAD_OPCODE);
        end
      end
    end
  endtask : t_reserved

  task automatic t_priv();
    logic [4:0] pl[4] = '{5'h10, 5'h16, 5'h17, 5'h19};
    tr(USR, 5'h04, 1'h0, 64'h0, TRAP_PRIV_ACCESS);
    tr(USR, 5'h18, 1'h0, 64'h0, TRAP_PRIV_ACCESS);
    tr(HYP, 5'h04, 1'h1, 64'h0, TRAP_NONE);
    tr(USR, 5'h04, 1'h0, 64'h0, TRAP_NONE);
    tr(USR, 5'h18, 1'h0, 64'h0, TRAP_NONE);
    tr(USR | 17'h1, 5'h04, 1'h0, 64'h0, TRAP_PRIV_ACCESS);
    tr(PRV, 5'h04, 1'h1, 64'h0, TRAP_BAD_OPCODE);
    tr(USR, 5'h04, 1'h1, 64'h0, TRAP_PRIV_OP);
    tr(PRV, 5'h18, 1'h1, 64'h0, TRAP_BAD_OPCODE);
    tr(USR, 5'h18, 1'h1, 64'h0, TRAP_BAD_OPCODE);
    foreach (pl[i]) begin
      tr(USR, pl[i], 1'h0, 64'h0, TRAP_PRIV_OP);
      tr(USR, pl[i], 1'h1, 64'h0, TRAP_PRIV_OP);
    end
    for (int n = 20; n < 22; n++) begin
      tr(HYP, n[4:0], 1'h0, 64'h0, TRAP_BAD_OPCODE);
      tr(USR, n[4:0], 1'h1, 64'h0, TRAP_PRIV_OP);
    end
    tr(PRV, 5'h10, 1'h1, 64'h1, TRAP_NONE);
    tr(USR, 5'h11, 1'h0, 64'h0, TRAP_PRIV_ACCESS);
    tr(PRV, 5'h10, 1'h1, 64'h0, TRAP_NONE);
    tr(USR, 5'h11, 1'h0, 64'h0, TRAP_NONE);
    tr(17'h0, 5'h13, 1'h0, 64'h0, TRAP_FLOAT_OFF);
    tr(USR, 5'h06, 1'h1, 64'h0, TRAP_NONE);
    tr(USR, 5'h13, 1'h1, 64'h5, TRAP_FLOAT_OFF);
    tr(USR, 5'h06, 1'h1, 64'h4, TRAP_NONE);
    tr(USR, 5'h13, 1'h0, 64'h0, TRAP_NONE);
    tr(17'h0, 5'h13, 1'h1, 64'h0, TRAP_FLOAT_OFF);
  endtask : t_priv

  task automatic t_counter();
    sr(HYP, 5'h04, 1'h1, 64'h1234);
    sr(HYP, 5'h04, 1'h0, 64'h0);
    check(rd, 64'h1234, "hold");
    sr(HYP, 5'h18, 1'h0, 64'h0);
    check(rd, 64'h127F, "sys low");
    sr(HYP, 5'h18, 1'h1, 64'h5500);
    sr(HYP, 5'h04, 1'h0, 64'h0);
    check(rd, 64'h5500, "alias");
    sr(HYP | CNT, 5'h04, 1'h0, 64'h0);
    prev = rd;
    sr(HYP | CNT, 5'h04, 1'h0, 64'h0);
    check(rd - prev, 64'hF, "count");
    sr(HYP, 5'h04, 1'h1, 64'h77);
    warmResetPin <= 1'h1;
    repeat (6) @(posedge clock);
    warmResetPin <= 1'h0;
    repeat (4) @(posedge clock);
    sr(HYP, 5'h04, 1'h0, 64'h0);
    check(rd, {1'h1, 63'h77}, "warm");
    tr(USR, 5'h04, 1'h0, 64'h0, TRAP_PRIV_ACCESS);
  endtask : t_counter

  // Pending is read after each compare change with a full scan period waited
  task automatic pend(input logic [16:0] c, input logic [63:0] e);
    repeat (130) @(posedge clock);
    sr(c, 5'h16, 1'h0, 64'h0);
    check(rd, e, "pending");
  endtask : pend

  task automatic t_irq();
    sr(HYP, 5'h04, 1'h1, 64'h85);
    sr(HYP, 5'h16, 1'h1, 64'h0);
    sr(HYP, 5'h17, 1'h1, {1'h1, 63'h80});
    pend(HYP, 64'h0);
    sr(HYP, 5'h17, 1'h1, 64'hFF);
    pend(IE3, 64'h1);
    check(irqLevel14, 8'h01, "irq tm");
    sr(IE4, 5'h16, 1'h0, 64'h0);
    check(irqLevel14, 8'h0, "irq pil4");
    sr(HYP, 5'h17, 1'h1, 64'h100);
    sr(HYP, 5'h15, 1'h1, 64'h1);
    pend(HYP, 64'h0);
    sr(HYP, 5'h19, 1'h1, 64'h80);
    pend(HYP | 17'h0D200, 64'h10000);
    check(irqLevel14, 8'h01, "irq sm");
    sr(HYP | 17'h0E200, 5'h16, 1'h0, 64'h0);
    check(irqLevel14, 8'h0, "irq pil14");
    sr(HYP, 5'h19, 1'h1, {1'h1, 63'h80});
    sr(HYP, 5'h15, 1'h1, 64'h10000);
    pend(HYP, 64'h0);
    sr(HYP, 5'h14, 1'h1, 64'h4000);
    pend(IE3, 64'h4000);
    check(irqLevel14, 8'h01, "irq soft");
    sr(HYP | 17'h03000, 5'h16, 1'h0, 64'h0);
    check(irqLevel14, 8'h0, "irq ie off");
    sr(HYP, 5'h15, 1'h1, 64'h4000);
    pend(HYP, 64'h0);
    // Compare left above the counter: no match yet, then one once it is reached
    sr(HYP | CNT, 5'h04, 1'h1, 64'h0);
    pend(HYP | CNT, 64'h0);
    pend(HYP | CNT, 64'h1);
  endtask : t_irq

  initial begin
    do_reset(20);
    t_bus();
    t_pc();
    t_reserved();
    t_priv();
    t_counter();
    t_irq();
    stop_test();
  end
endmodule : test_strand_state_regs_cycle_timer

bind ssrct_regs ssrct_properties #(.STRANDS(STRANDS)) u_props (
  .clock     (clock),
  .sys_rst   (sys_rst),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .paddr     (paddr),
  .prdata    (prdata),
  .pready    (pready),
  .pslverr   (pslverr),
  .irqLevel14(irqLevel14)
);

`default_nettype wire
